// [hw/ingress_class_action_merge.sv]
/*
  Ingress class action merge: layers the actions of up to three matching
  lookups onto the basic classification, keeps sticky per-entry hit flags,
  and extracts custom keys for the next stage. Registers over APB.
  Assumes lookup answers arrive with frame_req_i and that frame bytes for
  custom keys follow the merged result of the same frame.
*/
// Functional notes
// - Every matching lookup yields one action in one common format.
// - A lookup without a match changes nothing; no fallback action.
// - Actions apply in lookup order; the last enabled override wins.
// - Diffserv enable at bit 0 takes the 6-bit diffserv value.
// - Class enable at bit 7 takes the 3-bit class value.
// - Drop precedence enable at bit 11 takes the value at bit 12.
// - Policy group = (group AND NOT mask) OR (value AND mask).
// - Replace bit 40 clear adds VID operand; set substitutes it.
// - Filter select at bit 53 routes filter value to SMAC, DMAC, both.
// - Priority enable at bit 68 takes PCP at 69 and DEI at 72.
// - Pop enable at bit 73 takes pop count at 74, else port config.
// - Custom key field at 76: bits 1:0 first, 3:2 second lookup.
// - IP custom key is 40 bytes from frame byte 34.
// - Source address custom key is 40 bytes from frame byte 12.
// - Up to two VLAN tags are stripped before key extraction.
// - A match on an entry below HIT_ENTRIES sets that entry's sticky hit flag.
`timescale 1ns/100ps
`default_nettype none

// Field positions, offsets and reset values
`include "class_merge_map.svh"

module ingress_class_action_merge #(
  parameter int HIT_ENTRIES = 32
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`REG_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic frame_req_i,
  input wire class_merge_pkg::class_state_type basic_i,
  input wire class_merge_pkg::lookup_type [2:0] lookups_i,
  output logic result_valid_o,
  output class_merge_pkg::result_type result_o,
  input wire logic frame_valid_i,
  input wire logic frame_start_i,
  input wire logic [1:0] frame_tags_i,
  input wire logic [7:0] frame_byte_i,
  output class_merge_pkg::key_beat_type [1:0] key_beat_o
);
  import class_merge_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`ACT_POP_W-1:0] pop_cfg;
    logic [31:0] hit_flags;
    logic [31:0] merge_count;
    logic res_valid;
    result_type res;
  } state_type;

  state_type state;
  state_type next_state;

  // ========================================================================
  // Action decode: one common layout whatever entry type matched
  typedef struct packed {
    logic diffserv_override_en;
    logic [`ACT_DIFFSERV_OVERRIDE_VALUE_W-1:0] diffserv_override_value;
    logic class_override_en;
    logic [`ACT_CLASS_OVERRIDE_VALUE_W-1:0] class_override_value;
    logic drop_prec_override_en;
    logic drop_prec_override_value;
    logic [`ACT_PAG_W-1:0] policy_group_mask;
    logic [`ACT_PAG_W-1:0] policy_group_value;
    logic vlan_id_replace_sel;
    logic [`ACT_VID_W-1:0] vlan_id_operand;
    logic [`ACT_FILTER_ID_SELECT_W-1:0] filter_id_select;
    logic [`ACT_FID_W-1:0] filter_id_value;
    logic priority_elig_override_en;
    logic [`ACT_PCP_W-1:0] priority_override_value;
    logic eligibility_override_value;
    logic tag_pop_override_en;
    logic [`ACT_POP_W-1:0] tag_pop_count;
    logic [`ACT_KEY_SEL_W-1:0] custom_key_select;
  } action_fields_type;

  // Running classification between steps, with the filter id lanes that
  // an earlier step has already claimed
  typedef struct packed {
    result_type res;
    logic smac_claimed;
    logic dmac_claimed;
  } step_type;

  function automatic action_fields_type decode_action(
    input logic [`ACT_W-1:0] a
  );
    action_fields_type f;
    // Reserved bits and the hit bit carry no action
    f.diffserv_override_en = a[`ACT_DSCP_EN];
    f.diffserv_override_value = a[`ACT_DIFFSERV_OVERRIDE_VALUE +: `ACT_DIFFSERV_OVERRIDE_VALUE_W];
    f.class_override_en = a[`ACT_QOS_EN];
    f.class_override_value = a[`ACT_CLASS_OVERRIDE_VALUE +: `ACT_CLASS_OVERRIDE_VALUE_W];
    f.drop_prec_override_en = a[`ACT_DP_EN];
    f.drop_prec_override_value = a[`ACT_DROP_PREC_OVERRIDE_VALUE];
    f.policy_group_mask = a[`ACT_PAG_MASK +: `ACT_PAG_W];
    f.policy_group_value = a[`ACT_POLICY_GROUP_VALUE +: `ACT_PAG_W];
    f.vlan_id_replace_sel = a[`ACT_VID_REPL];
    f.vlan_id_operand = a[`ACT_VID_VAL +: `ACT_VID_W];
    f.filter_id_select = a[`ACT_FILTER_ID_SELECT +: `ACT_FILTER_ID_SELECT_W];
    f.filter_id_value = a[`ACT_FILTER_ID_VALUE +: `ACT_FID_W];
    f.priority_elig_override_en = a[`ACT_PCP_EN];
    f.priority_override_value = a[`ACT_PRIORITY_OVERRIDE_VALUE +: `ACT_PCP_W];
    f.eligibility_override_value = a[`ACT_ELIGIBILITY_OVERRIDE_VALUE];
    f.tag_pop_override_en = a[`ACT_POP_EN];
    f.tag_pop_count = a[`ACT_POP_CNT +: `ACT_POP_W];
    f.custom_key_select = a[`ACT_KEY_SEL +: `ACT_KEY_SEL_W];
    return f;
  endfunction

  // Step zero is the basic classification and the port's pop count
  function automatic step_type seed_step(
    input class_state_type basic,
    input logic [`ACT_POP_W-1:0] port_pop
  );
    step_type s;
    s = '0;
    s.res.cls = basic;
    s.res.tag_pop_count = port_pop;
    return s;
  endfunction

  // One lookup's action layered onto the step before it
  function automatic step_type apply_step(
    input step_type prev,
    input lookup_type lk
  );
    step_type s;
    action_fields_type f;
    s = prev;
    f = decode_action(lk.action);
    if (lk.hit) begin
      if (f.diffserv_override_en) begin
        s.res.cls.diffserv = f.diffserv_override_value;
      end
      if (f.class_override_en) begin
        s.res.cls.qos_class = f.class_override_value;
      end
      if (f.drop_prec_override_en) begin
        s.res.cls.drop_prec = f.drop_prec_override_value;
      end
      // masked policy group
      // A zero mask leaves the group as it was
      s.res.cls.policy_group = (s.res.cls.policy_group &
        ~f.policy_group_mask) | (f.policy_group_value & f.policy_group_mask);
      if (f.vlan_id_replace_sel) begin
        s.res.cls.vlan_id = f.vlan_id_operand;
      end else begin
        s.res.cls.vlan_id = s.res.cls.vlan_id + f.vlan_id_operand;
      end
      // filter id select
      // A later select of 0 keeps an earlier claim
      if (f.filter_id_select[0]) begin
        s.smac_claimed = 1'b1;
        s.res.smac_filter_id = f.filter_id_value;
      end
      if (f.filter_id_select[1]) begin
        s.dmac_claimed = 1'b1;
        s.res.dmac_filter_id = f.filter_id_value;
      end
      if (f.priority_elig_override_en) begin
        s.res.cls.priority_code = f.priority_override_value;
        s.res.cls.eligibility = f.eligibility_override_value;
      end
      if (f.tag_pop_override_en) begin
        s.res.tag_pop_count = f.tag_pop_count;
      end
      if (f.custom_key_select[1:0] != 2'h0) begin
        s.res.custom_key_select[1:0] = f.custom_key_select[1:0];
      end
      if (f.custom_key_select[3:2] != 2'h0) begin
        s.res.custom_key_select[3:2] = f.custom_key_select[3:2];
      end
    end
    return s;
  endfunction

  // ========================================================================
  // Merge chain: basic classification, then lookups 0, 1 and 2
  // All three steps settle in one cycle; the VID adders are the deep path
  step_type chain [0:3];
  result_type merged;
  genvar k;

  assign chain[0] = seed_step(basic_i, state.pop_cfg);

  generate
    for (k = 0; k < 3; k++) begin : gen_step
      // lookup k layered onto step k
      assign chain[k+1] = apply_step(chain[k], lookups_i[k]);
    end
  endgenerate

  // a lane no step claimed takes the zero-prefixed VID
  always_comb begin
    merged = chain[3].res;
    if (!chain[3].smac_claimed) begin
      merged.smac_filter_id = {1'b0, chain[3].res.cls.vlan_id};
    end
    if (!chain[3].dmac_claimed) begin
      merged.dmac_filter_id = {1'b0, chain[3].res.cls.vlan_id};
    end
  end

  // ========================================================================
  // Hit flag set vector, one bit per entry
  // Entries at or beyond HIT_ENTRIES are not tracked
  logic [31:0] hit_set;

  generate
    for (k = 0; k < 32; k++) begin : gen_hit
      assign hit_set[k] = frame_req_i && (k < HIT_ENTRIES) &&
        ((lookups_i[0].hit && lookups_i[0].entry == 8'(k)) ||
        (lookups_i[1].hit && lookups_i[1].entry == 8'(k)) ||
        (lookups_i[2].hit && lookups_i[2].entry == 8'(k)));
    end
  endgenerate

  // ========================================================================
  // APB slave and state update
  always_comb begin
    logic access;
    logic [31:0] hit_clear;
    logic mapped;
    access = psel_i && penable_i;
    hit_clear = '0;
    mapped = (paddr_i == `REG_POP_CFG) || (paddr_i == `REG_HIT_FLAGS) ||
      (paddr_i == `REG_MERGE_COUNT);
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (access && !state.pready) begin
      // One wait state, then answer with registered data
      next_state.pready = 1'b1;
      // Unmapped words answer with an error and read as zero
      next_state.pslverr = !mapped;
      next_state.prdata = '0;
      if (!pwrite_i) begin
        unique case (paddr_i)
          `REG_POP_CFG: begin
            next_state.prdata = {30'h0, state.pop_cfg};
          end
          `REG_HIT_FLAGS: begin
            next_state.prdata = state.hit_flags;
          end
          `REG_MERGE_COUNT: begin
            next_state.prdata = state.merge_count;
          end
          default: begin
            next_state.prdata = '0;
          end
        endcase
      end
    end
    // Writes land on the edge that sees pready_o high
    if (access && state.pready && pwrite_i) begin
      if (paddr_i == `REG_POP_CFG) begin
        next_state.pop_cfg = pwdata_i[`ACT_POP_W-1:0];
      end
      if (paddr_i == `REG_HIT_FLAGS) begin
        hit_clear = pwdata_i;
      end
    end
    // only software clears; a new hit beats the clear
    next_state.hit_flags = ((state.hit_flags & ~hit_clear) | hit_set) &
      ((HIT_ENTRIES >= 32) ? 32'hFFFF_FFFF :
      ((32'h0000_0001 << HIT_ENTRIES) - 32'h0000_0001));
    next_state.res_valid = frame_req_i;
    if (frame_req_i) begin
      // whole chain resolved in one cycle
      next_state.res = merged;
      next_state.merge_count = state.merge_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
      state.pop_cfg <= `RST_POP_CFG;
      state.hit_flags <= `RST_HIT_FLAGS;
      state.merge_count <= `RST_MERGE_COUNT;
    end else begin
      state <= next_state;
    end
  end

  assign pready_o = state.pready;
  assign prdata_o = state.prdata;
  assign pslverr_o = state.pslverr;
  assign result_valid_o = state.res_valid;
  assign result_o = state.res;

  // ========================================================================
  // Custom key extraction, one extractor per next-stage lookup
  // Selectors come from the registered result, so a key always uses the
  // selectors of the latest merged frame
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_key
      custom_key_extract u_extract (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .key_sel_i(state.res.custom_key_select[2*g +: 2]),
        .frame_valid_i(frame_valid_i),
        .frame_start_i(frame_start_i),
        .frame_tags_i(frame_tags_i),
        .frame_byte_i(frame_byte_i),
        .beat_o(key_beat_o[g])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// [hw/class_merge_map.svh]
/*
  Constants of the ingress class action merge: register offsets, action
  vector field positions and widths, reset values and key extraction counts.
  Assumes it is included by bare name, before the package that uses it.
*/
`ifndef CLASS_MERGE_MAP_SVH
`define CLASS_MERGE_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define REG_POP_CFG 12'h000
`define REG_HIT_FLAGS 12'h004
`define REG_MERGE_COUNT 12'h008
`define REG_ADDR_W 12

// ==========================================================================
// Reset values
`define RST_POP_CFG 2'h0
`define RST_HIT_FLAGS 32'h0000_0000
`define RST_MERGE_COUNT 32'h0000_0000

// ==========================================================================
// Action vector fields: lowest bit, then width
`define ACT_W 81
`define ACT_DSCP_EN 0
`define ACT_DIFFSERV_OVERRIDE_VALUE 1
`define ACT_DIFFSERV_OVERRIDE_VALUE_W 6
`define ACT_QOS_EN 7
`define ACT_CLASS_OVERRIDE_VALUE 8
`define ACT_CLASS_OVERRIDE_VALUE_W 3
`define ACT_DP_EN 11
`define ACT_DROP_PREC_OVERRIDE_VALUE 12
`define ACT_PAG_MASK 13
`define ACT_POLICY_GROUP_VALUE 21
`define ACT_PAG_W 8
`define ACT_RSVD 29
`define ACT_RSVD_W 9
`define ACT_VID_REPL 40
`define ACT_VID_VAL 41
`define ACT_VID_W 12
`define ACT_FILTER_ID_SELECT 53
`define ACT_FILTER_ID_SELECT_W 2
`define ACT_FILTER_ID_VALUE 55
`define ACT_FID_W 13
`define ACT_PCP_EN 68
`define ACT_PRIORITY_OVERRIDE_VALUE 69
`define ACT_PCP_W 3
`define ACT_ELIGIBILITY_OVERRIDE_VALUE 72
`define ACT_POP_EN 73
`define ACT_POP_CNT 74
`define ACT_POP_W 2
`define ACT_KEY_SEL 76
`define ACT_KEY_SEL_W 4
`define ACT_HIT 80

// ==========================================================================
// Custom key extraction
`define KEY_IP_START 8'd34
`define KEY_SMAC_START 8'd12
`define KEY_LEN 8'd40
`define TAG_BYTES 8'd4
`define MAX_TAGS 2'd2
`define ENTRY_IDX_W 8

`endif

// [hw/class_merge_pkg.sv]
/*
  Types of the ingress class action merge: classification state, lookup
  answers, merged result and custom key beats.
  Assumes class_merge_map.svh is reachable on the include path.
*/
`include "class_merge_map.svh"

package class_merge_pkg;

  // ========================================================================
  // Custom key selector codes
  typedef enum logic [1:0] {
    KEY_OFF = 2'h0,
    KEY_IP = 2'h1,
    KEY_SMAC = 2'h2
  } key_sel_type;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [`ACT_DIFFSERV_OVERRIDE_VALUE_W-1:0] diffserv;
    logic [`ACT_CLASS_OVERRIDE_VALUE_W-1:0] qos_class;
    logic drop_prec;
    logic [`ACT_PAG_W-1:0] policy_group;
    logic [`ACT_VID_W-1:0] vlan_id;
    logic [`ACT_PCP_W-1:0] priority_code;
    logic eligibility;
  } class_state_type;

  typedef struct packed {
    logic hit;
    logic [`ENTRY_IDX_W-1:0] entry;
    logic [`ACT_W-1:0] action;
  } lookup_type;

  typedef struct packed {
    class_state_type cls;
    logic [`ACT_FID_W-1:0] smac_filter_id;
    logic [`ACT_FID_W-1:0] dmac_filter_id;
    logic [`ACT_POP_W-1:0] tag_pop_count;
    logic [`ACT_KEY_SEL_W-1:0] custom_key_select;
  } result_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } key_beat_type;

endpackage

// [hw/custom_key_extract.sv]
/*
  Custom key extractor for one next-stage lookup: picks 40 bytes out of
  the frame byte stream at the selected position once VLAN tags are
  stripped. Assumes frame bytes arrive in order, one per valid cycle.
*/
`timescale 1ns/100ps
`default_nettype none

`include "class_merge_map.svh"

module custom_key_extract (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [1:0] key_sel_i,
  input wire logic frame_valid_i,
  input wire logic frame_start_i,
  input wire logic [1:0] frame_tags_i,
  input wire logic [7:0] frame_byte_i,
  output class_merge_pkg::key_beat_type beat_o
);
  import class_merge_pkg::*;

  typedef struct packed {
    logic [7:0] pos;
    key_beat_type beat;
  } state_type;

  state_type state;
  state_type next_state;

  // ========================================================================
  // Window search
  always_comb begin
    logic [7:0] p;
    logic [7:0] first;
    logic [1:0] tags;
    p = frame_start_i ? 8'h00 : state.pos;
    tags = (frame_tags_i > `MAX_TAGS) ? `MAX_TAGS : frame_tags_i;
    first = (key_sel_i == KEY_IP) ? `KEY_IP_START : `KEY_SMAC_START;
    first = first + (`TAG_BYTES * {6'h00, tags});
    next_state = state;
    next_state.beat = '0;
    if (frame_valid_i) begin
      if (p != 8'hFF) begin
        next_state.pos = p + 8'h01;
      end
      if ((key_sel_i == KEY_IP || key_sel_i == KEY_SMAC) && p >= first &&
          p < first + `KEY_LEN) begin
        next_state.beat.valid = 1'b1;
        next_state.beat.last = (p == first + `KEY_LEN - 8'h01);
        next_state.beat.data = frame_byte_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign beat_o = state.beat;

endmodule

`default_nettype wire

// [testbench/ingress_class_action_merge_properties.sv]
/*
  Port checker of the ingress class action merge.
  Assumes class_merge_pkg is compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Checker
module merge_checker
  import class_merge_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic frame_req_i,
  input wire class_state_type basic_i,
  input wire lookup_type [2:0] lookups_i,
  input wire logic result_valid_o,
  input wire result_type result_o,
  input wire key_beat_type [1:0] key_beat_o
);
  import class_merge_pkg::*;
  logic [80:0] a2;
  logic h2;
  logic none;
  assign a2 = lookups_i[2].action;
  assign h2 = frame_req_i && lookups_i[2].hit;
  assign none = !lookups_i[0].hit && !lookups_i[1].hit && !lookups_i[2].hit;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_answer;
    frame_req_i |=> result_valid_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no result after request");
  property p_quiet;
    !frame_req_i |=> !result_valid_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("result without request");
  property p_nomatch;
    frame_req_i && none |=> result_o.cls == $past(basic_i);
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("state changed without match");
  property p_dscp;
    h2 && a2[0] |=> result_o.cls.diffserv == $past(a2[6:1]);
  endproperty
  a_dscp: assert property (p_dscp)
    else $error("last diffserv override lost");
  property p_dp;
    h2 && a2[11] |=> result_o.cls.drop_prec == $past(a2[12]);
  endproperty
  a_dp: assert property (p_dp)
    else $error("drop precedence override lost");
  property p_pg;
    h2 && a2[20:13] == 8'hFF |=> result_o.cls.policy_group == $past(a2[28:21]);
  endproperty
  a_pg: assert property (p_pg)
    else $error("policy group not masked in");
  property p_vid;
    h2 && a2[40] |=> result_o.cls.vlan_id == $past(a2[52:41]);
  endproperty
  a_vid: assert property (p_vid)
    else $error("vlan id not replaced");
  property p_pcp;
    h2 && a2[68] |=> {result_o.cls.priority_code, result_o.cls.eligibility}
      == $past({a2[71:69], a2[72]});
  endproperty
  a_pcp: assert property (p_pcp)
    else $error("priority override lost");
  property p_pop;
    h2 && a2[73] |=> result_o.tag_pop_count == $past(a2[75:74]);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop count override lost");

  c_all: cover property (frame_req_i && lookups_i[0].hit && lookups_i[1].hit && h2);
  c_key: cover property (key_beat_o[1].last);
  c_err: cover property (pready_o && pslverr_o);
endmodule

bind ingress_class_action_merge merge_checker u_chk (.clk_sys_i, .reset_i,
  .pready_o, .pslverr_o, .frame_req_i, .basic_i, .lookups_i,
  .result_valid_o, .result_o, .key_beat_o);

`default_nettype wire

// [testbench/frame_source.sv]
/*
  Far-side frame byte source: streams 120 bytes, value position^5A.
  Assumes one go pulse per frame; stall pauses the stream.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Frame source
module frame_source (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic [1:0] tags_i,
  output logic valid_o,
  output logic start_o,
  output logic [1:0] tags_o,
  output logic [7:0] byte_o
);
  logic [7:0] pos;
  logic run;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pos <= 8'h00;
      run <= 1'b0;
    end else if (go_i) begin
      pos <= 8'h00;
      run <= 1'b1;
    end else if (run && !stall_i) begin
      pos <= pos + 8'h01;
      run <= pos != 8'd119;
    end
  end
  assign valid_o = run && !stall_i;
  assign start_o = valid_o && pos == 8'h00;
  assign tags_o = tags_i;
  // Idle or stalled: inverted byte, so stale data never looks valid
  assign byte_o = valid_o ? pos ^ 8'h5A : ~(pos ^ 8'h5A);
endmodule

`default_nettype wire

// [testbench/test_ingress_class_action_merge.sv]
/*
  Self-checking bench of the ingress class action merge.
  Assumes the package, the design and frame_source are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Bench
module test_ingress_class_action_merge;
  import class_merge_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h0231, hit_exp = '0;
  logic [31:0] cnt_exp = '0;
  logic pready, pslverr, frame_req = 0, res_v, go = 0, stall = 0, err;
  logic fv, fs;
  logic [1:0] ft, tags = '0, pp;
  logic [7:0] fb;
  class_state_type basic = '0;
  lookup_type [2:0] lookups = '0;
  result_type res;
  key_beat_type [1:0] kb;
  int error_cnt = 0, checks = 0;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

  always #5 clk_sys_i = ~clk_sys_i;

  ingress_class_action_merge u_dut (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .frame_req_i(frame_req), .basic_i(basic), .lookups_i(lookups),
    .result_valid_o(res_v), .result_o(res), .frame_valid_i(fv),
    .frame_start_i(fs), .frame_tags_i(ft), .frame_byte_i(fb),
    .key_beat_o(kb));
  frame_source u_src (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .go_i(go), .stall_i(stall), .tags_i(tags), .valid_o(fv),
    .start_o(fs), .tags_o(ft), .byte_o(fb));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic result_type merge(class_state_type b,
      lookup_type [2:0] l, logic [1:0] p);
    result_type r;
    logic [80:0] a;
    logic sf, df;
    r = '0;
    r.cls = b;
    r.tag_pop_count = p;
    sf = 0;
    df = 0;
    for (int i = 0; i < 3; i++) if (l[i].hit) begin
      a = l[i].action;
      if (a[0]) r.cls.diffserv = a[6:1];
      if (a[7]) r.cls.qos_class = a[10:8];
      if (a[11]) r.cls.drop_prec = a[12];
      r.cls.policy_group = (r.cls.policy_group & ~a[20:13]) |
        (a[28:21] & a[20:13]);
      r.cls.vlan_id = a[40] ? a[52:41] : r.cls.vlan_id + a[52:41];
      if (a[53]) {sf, r.smac_filter_id} = {1'b1, a[67:55]};
      if (a[54]) {df, r.dmac_filter_id} = {1'b1, a[67:55]};
      if (a[68]) {r.cls.priority_code, r.cls.eligibility} = {a[71:69], a[72]};
      if (a[73]) r.tag_pop_count = a[75:74];
      if (a[77:76] != 2'h0) r.custom_key_select[1:0] = a[77:76];
      if (a[79:78] != 2'h0) r.custom_key_select[3:2] = a[79:78];
    end
    // unselected lanes use the vlan id
    if (!sf) r.smac_filter_id = {1'b0, r.cls.vlan_id};
    if (!df) r.dmac_filter_id = {1'b0, r.cls.vlan_id};
    return r;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // Read at the edge itself, before the edge's own updates
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame(input class_state_type b, input lookup_type [2:0] l);
    @(posedge clk_sys_i);
    basic <= b;
    lookups <= l;
    frame_req <= 1'b1;
    @(posedge clk_sys_i);
    frame_req <= 1'b0;
    cnt_exp++;
    for (int i = 0; i < 3; i++) if (l[i].hit) hit_exp[l[i].entry[4:0]] = 1'b1;
    // Result stands for one cycle only: look mid-cycle
    @(negedge clk_sys_i);
    `CHK("valid", 1'b1, res_v)
    `CHK("result", merge(b, l, pp), res)
  endtask

  task automatic rand_frame(input int mode);
    logic [95:0] x;
    lookup_type [2:0] l;
    x = {rnd(), rnd(), rnd()};
    for (int i = 0; i < 3; i++) begin
      x = {rnd(), rnd(), rnd()};
      l[i] = x[89:0];
      l[i].entry[7:5] = 3'h0;
      l[i].action[37:29] = 9'h000;
      if (mode == 1) l[i].hit = 1'b0;
      if (mode == 2) l[i].hit = 1'b1;
      if (mode == 2) l[i].action |= 81'h210_0000_0100_001F_E801;
    end
    frame(x[33:0], l);
  endtask

  task automatic keys(input logic [1:0] t);
    lookup_type [2:0] l;
    int n[2];
    int last[2];
    logic [7:0] first[2];
    logic [7:0] skip;
    n = '{0, 0};
    last = '{0, 0};
    // Three tags are stripped as two
    skip = (t == 2'd3) ? 8'd8 : {4'h0, t, 2'b00};
    l = '0;
    l[0].hit = 1'b1;
    l[0].action[79:76] = 4'b0110;
    frame('0, l);
    @(posedge clk_sys_i);
    tags <= t;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (300) begin
      @(posedge clk_sys_i);
      rd = rnd();
      stall <= rd[0];
      #1;
      for (int k = 0; k < 2; k++) if (kb[k].valid === 1'b1) begin
        n[k]++;
        if (n[k] == 1) first[k] = kb[k].data;
        if (kb[k].last === 1'b1) last[k] = n[k];
      end
    end
    stall <= 1'b0;
    `CHK("beats0", 40, n[0])
    `CHK("last0", 40, last[0])
    `CHK("first0", (8'd12 + skip) ^ 8'h5A, first[0])
    `CHK("beats1", 40, n[1])
    `CHK("last1", 40, last[1])
    `CHK("first1", (8'd34 + skip) ^ 8'h5A, first[1])
  endtask

  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the roughly 1400 cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd = rnd();
    pp = rd[1:0];
    apb(1'b1, 12'h000, {30'h0, pp});
    apb(1'b0, 12'h000, 32'h0);
    `CHK("pop_cfg", {30'h0, pp}, rd)
    // Unmapped word must answer with an error
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("slverr", 1'b1, err)
    for (int i = 0; i < 42; i++) rand_frame(i % 3);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("hit_flags", hit_exp, rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("merge_count", cnt_exp, rd)
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("hit_clear", 32'h0, rd)
    for (int t = 0; t < 4; t++) keys(t[1:0]);
    print_verdict();
  end
endmodule

`default_nettype wire
